// ===== logic/lpms_pkg.sv
// constants and types for the low power mode sequencer
package lpms_pkg;
  localparam int CLK_MHZ = 125;
  // settle times in microseconds, as printed, except the wake time in units of 10 us
  localparam int T_RST_NONE_US = 1500;
  localparam int T_RST_RO_US = 7000;
  localparam int T_RST_XO_US = 94000;
  localparam int T_WAKE_US100 = 42; // 0.42 ms in units of 10 us
  localparam int T_SBY_RO_US = 6200;
  localparam int T_SBY_XO_US = 93000;
  localparam int T_RX_CH_US = 125;
  localparam int T_RX_US = 61;
  localparam int T_TX_CH_US = 131;
  localparam int T_TX_US = 67;
  localparam int T_SW_US = 150;
  // times convert to whole cycles exactly; cyc() loads the count less one so each wait lasts the full count
  localparam int CYC_RST_NONE = T_RST_NONE_US * CLK_MHZ;
  localparam int CYC_RST_RO = T_RST_RO_US * CLK_MHZ;
  localparam int CYC_RST_XO = T_RST_XO_US * CLK_MHZ;
  localparam int CYC_WAKE = T_WAKE_US100 * 10 * CLK_MHZ;
  localparam int CYC_SBY_RO = T_SBY_RO_US * CLK_MHZ;
  localparam int CYC_SBY_XO = T_SBY_XO_US * CLK_MHZ;
  localparam int CYC_RX_CH = T_RX_CH_US * CLK_MHZ;
  localparam int CYC_RX = T_RX_US * CLK_MHZ;
  localparam int CYC_TX_CH = T_TX_CH_US * CLK_MHZ;
  localparam int CYC_TX = T_TX_US * CLK_MHZ;
  localparam int CYC_SW = T_SW_US * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam logic [4:0] PWR_MIN = 5'h00; // code 0 is -18 dBm
  localparam logic [4:0] PWR_MAX = 5'h1A; // code 26 is +8 dBm
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef enum logic [1:0] {
    LPMS_LS_NONE,
    LPMS_LS_RING,
    LPMS_LS_XTAL
  } lpms_ls_e;

  typedef enum logic [1:0] {
    LPMS_REQ_ACTIVE,
    LPMS_REQ_RX,
    LPMS_REQ_TX,
    LPMS_REQ_SLEEP
  } lpms_req_e;

  typedef enum logic [3:0] {
    LPMS_RESET,
    LPMS_BOOT,
    LPMS_STANDBY,
    LPMS_SLEEP,
    LPMS_WAKE,
    LPMS_ACTIVE,
    LPMS_TO_RX,
    LPMS_RX,
    LPMS_TO_TX,
    LPMS_TX
  } lpms_mode_e;

  // power gates driven into the chip
  typedef struct packed {
    logic dig_reg_on;
    logic host_port_on;
    logic low_speed_osc_on;
    logic high_speed_osc_on;
    logic core_on;
    logic second_bank_on;
    logic synth_on;
    logic rx_on;
    logic tx_on;
  } lpms_gate_s;
endpackage : lpms_pkg

// ===== logic/lpms_sequencer.sv
// low power mode sequencer: mode state machine and host port wake logic
`timescale 1ns/1ps
module lpms_sequencer #(
  parameter int RST_NONE = lpms_pkg::CYC_RST_NONE,
  parameter int RST_RO = lpms_pkg::CYC_RST_RO,
  parameter int RST_XO = lpms_pkg::CYC_RST_XO,
  parameter int WAKE = lpms_pkg::CYC_WAKE,
  parameter int SBY_RO = lpms_pkg::CYC_SBY_RO,
  parameter int SBY_XO = lpms_pkg::CYC_SBY_XO,
  parameter int RX_CH = lpms_pkg::CYC_RX_CH,
  parameter int RX_NC = lpms_pkg::CYC_RX,
  parameter int TX_CH = lpms_pkg::CYC_TX_CH,
  parameter int TX_NC = lpms_pkg::CYC_TX,
  parameter int SW = lpms_pkg::CYC_SW
) (
  // system
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic external_reset_n,
  // host serial port, clocked by the host
  input wire logic port_clk,
  input wire logic port_select_n,
  input wire logic port_mosi,
  output logic port_miso_o,
  output logic port_miso_oe,
  output logic data_pending_o,
  output logic data_pending_oe,
  // configuration and core requests
  input wire lpms_pkg::lpms_ls_e ls_src,
  input wire logic bank2_off_cfg,
  input wire logic channel_change,
  input wire lpms_pkg::lpms_req_e mode_req,
  input wire logic mode_req_valid,
  input wire logic timer_expired,
  input wire logic data_ready,
  input wire logic [4:0] tx_power_in,
  // status
  output lpms_pkg::lpms_mode_e mode,
  output lpms_pkg::lpms_gate_s gate,
  output logic [4:0] tx_power,
  output logic host_wake_seen,
  output logic fw_update_cmd
);
  initial begin
    if (WAKE < 2 || RST_NONE < 2 || SW < 2)
      $error("lpms_sequencer: counts below two cycles");
  end

  // reset release and pin synchronisers
  logic [1:0] arst_sync;
  logic rst_n;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) arst_sync <= 2'h0;
    else arst_sync <= {arst_sync[0], 1'b1};
  end
  assign rst_n = arst_sync[1];

  // link side: shift in a command byte every eight clocks while selected
  logic [7:0] sh_r;
  logic [2:0] bit_r;
  logic byte_tgl_r;
  logic [7:0] byte_r;
  always_ff @(posedge port_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      byte_tgl_r <= 1'b0;
      byte_r <= 8'h00;
    end else if (!port_select_n) begin
      sh_r <= {sh_r[6:0], port_mosi};
      bit_r <= bit_r + 3'h1;
      if (bit_r == 3'h7) begin
        byte_r <= {sh_r[6:0], port_mosi}; // stable until next toggle
        byte_tgl_r <= ~byte_tgl_r;
      end
    end
  end

  // state record
  typedef struct packed {
    logic [1:0] rst_pin;
    logic [1:0] sel;
    logic sel_d;
    logic [2:0] tgl;
    logic [7:0] cmd;
    lpms_pkg::lpms_mode_e mode;
    logic [lpms_pkg::CNT_W-1:0] cnt;
    logic [1:0] sleep_pend;
    lpms_pkg::lpms_gate_s gate;
    logic [4:0] pwr;
    logic wake_seen;
    logic fw_cmd;
    logic miso_oe;
    logic irq;
    logic irq_oe;
  } lpms_state_s;

  lpms_state_s s_r, s_nxt;

  function automatic logic [lpms_pkg::CNT_W-1:0] cyc(input int n);
    cyc = lpms_pkg::CNT_W'(n - 1);
  endfunction : cyc

  function automatic lpms_pkg::lpms_gate_s gates(
      input lpms_pkg::lpms_mode_e m, input logic ls_run, input logic b2off);
    lpms_pkg::lpms_gate_s g;
    g = '0;
    g.dig_reg_on = (m != lpms_pkg::LPMS_RESET);
    g.host_port_on = (m != lpms_pkg::LPMS_RESET);
    g.second_bank_on = g.dig_reg_on;
    case (m)
      lpms_pkg::LPMS_SLEEP: begin
        g.low_speed_osc_on = ls_run;
        g.second_bank_on = !b2off;
      end
      lpms_pkg::LPMS_STANDBY: begin
        g.low_speed_osc_on = 1'b0;
        g.second_bank_on = !b2off;
      end
      lpms_pkg::LPMS_RESET: ;
      default: begin
        g.low_speed_osc_on = ls_run;
        g.high_speed_osc_on = 1'b1;
        g.core_on = (m != lpms_pkg::LPMS_WAKE) &&
                    (m != lpms_pkg::LPMS_BOOT);
      end
    endcase
    g.synth_on = (m == lpms_pkg::LPMS_RX) || (m == lpms_pkg::LPMS_TX);
    g.rx_on = (m == lpms_pkg::LPMS_RX);
    g.tx_on = (m == lpms_pkg::LPMS_TX);
    return g;
  endfunction : gates

  // next state
  always_comb begin
    logic sel_fall;
    logic lowp;
    logic ls_run;
    sel_fall = 1'b0;
    lowp = 1'b0;
    ls_run = 1'b0;
    s_nxt = s_r;
    s_nxt.rst_pin = {s_r.rst_pin[0], external_reset_n};
    s_nxt.sel = {s_r.sel[0], port_select_n};
    s_nxt.sel_d = s_r.sel[1];
    s_nxt.tgl = {s_r.tgl[1:0], byte_tgl_r};
    sel_fall = s_r.sel_d && !s_r.sel[1];
    ls_run = (ls_src != lpms_pkg::LPMS_LS_NONE);
    s_nxt.fw_cmd = 1'b0;
    if (s_r.tgl[2] != s_r.tgl[1]) begin
      s_nxt.cmd = byte_r; // toggle-synchronised word
      s_nxt.fw_cmd = byte_r[7];
    end
    if (s_r.cnt != '0) s_nxt.cnt = s_r.cnt - 1'b1;
    s_nxt.wake_seen = 1'b0;
    if (mode_req_valid && mode_req == lpms_pkg::LPMS_REQ_SLEEP)
      s_nxt.sleep_pend = 2'h1;
    case (s_r.mode)
      lpms_pkg::LPMS_RESET: begin
        s_nxt.mode = lpms_pkg::LPMS_BOOT;
        s_nxt.cnt = (ls_src == lpms_pkg::LPMS_LS_XTAL) ? cyc(RST_XO) :
                    (ls_src == lpms_pkg::LPMS_LS_RING) ? cyc(RST_RO) :
                    cyc(RST_NONE);
      end
      lpms_pkg::LPMS_BOOT, lpms_pkg::LPMS_WAKE:
        if (s_r.cnt == '0) s_nxt.mode = lpms_pkg::LPMS_ACTIVE;
      lpms_pkg::LPMS_STANDBY, lpms_pkg::LPMS_SLEEP: begin
        if (sel_fall) begin
          s_nxt.wake_seen = 1'b1;
          s_nxt.mode = lpms_pkg::LPMS_WAKE;
          s_nxt.cnt = (s_r.mode == lpms_pkg::LPMS_SLEEP) ? cyc(WAKE) :
                      (ls_src == lpms_pkg::LPMS_LS_XTAL) ? cyc(SBY_XO) :
                      (ls_src == lpms_pkg::LPMS_LS_RING) ? cyc(SBY_RO) :
                      cyc(WAKE);
        end else if (timer_expired && s_r.mode == lpms_pkg::LPMS_SLEEP) begin
          s_nxt.mode = lpms_pkg::LPMS_WAKE;
          s_nxt.cnt = cyc(WAKE);
        end
      end
      lpms_pkg::LPMS_ACTIVE:
        if (s_r.sleep_pend != 2'h0 || (mode_req_valid &&
            mode_req == lpms_pkg::LPMS_REQ_SLEEP)) begin
          s_nxt.sleep_pend = 2'h0;
          s_nxt.mode = ls_run ? lpms_pkg::LPMS_SLEEP : lpms_pkg::LPMS_STANDBY;
        end else if (mode_req_valid && mode_req == lpms_pkg::LPMS_REQ_RX) begin
          s_nxt.mode = lpms_pkg::LPMS_TO_RX;
          s_nxt.cnt = channel_change ? cyc(RX_CH) : cyc(RX_NC);
        end else if (mode_req_valid && mode_req == lpms_pkg::LPMS_REQ_TX) begin
          s_nxt.mode = lpms_pkg::LPMS_TO_TX;
          s_nxt.cnt = channel_change ? cyc(TX_CH) : cyc(TX_NC);
        end
      lpms_pkg::LPMS_TO_RX:
        if (s_r.cnt == '0) s_nxt.mode = lpms_pkg::LPMS_RX;
      lpms_pkg::LPMS_TO_TX:
        if (s_r.cnt == '0) s_nxt.mode = lpms_pkg::LPMS_TX;
      lpms_pkg::LPMS_RX, lpms_pkg::LPMS_TX:
        if (mode_req_valid) begin
          if (mode_req == lpms_pkg::LPMS_REQ_TX &&
              s_r.mode == lpms_pkg::LPMS_RX) begin
            s_nxt.mode = lpms_pkg::LPMS_TO_TX;
            s_nxt.cnt = cyc(SW);
          end else if (mode_req == lpms_pkg::LPMS_REQ_RX &&
                       s_r.mode == lpms_pkg::LPMS_TX) begin
            s_nxt.mode = lpms_pkg::LPMS_TO_RX;
            s_nxt.cnt = cyc(SW);
          end else if (mode_req != lpms_pkg::LPMS_REQ_RX &&
                       mode_req != lpms_pkg::LPMS_REQ_TX) begin
            s_nxt.mode = lpms_pkg::LPMS_ACTIVE; // radio released first
          end
        end
      default: s_nxt.mode = lpms_pkg::LPMS_RESET;
    endcase
    // pin reset overrides everything but the tx power load and wipes retained state
    if (!s_r.rst_pin[1]) begin
      s_nxt = '0;
      s_nxt.rst_pin = {s_r.rst_pin[0], external_reset_n};
      s_nxt.mode = lpms_pkg::LPMS_RESET;
    end
    if (tx_power_in <= lpms_pkg::PWR_MAX)
      s_nxt.pwr = tx_power_in;
    s_nxt.gate = gates(s_nxt.mode, ls_run, bank2_off_cfg);
    lowp = (s_nxt.mode == lpms_pkg::LPMS_SLEEP) ||
           (s_nxt.mode == lpms_pkg::LPMS_STANDBY) ||
           (s_nxt.mode == lpms_pkg::LPMS_RESET);
    s_nxt.miso_oe = !lowp;
    s_nxt.irq_oe = !lowp;
    s_nxt.irq = !lowp && data_ready;
  end

  // single state register; reset gives the all-unpowered record
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign port_miso_o = 1'b0;
  assign port_miso_oe = s_r.miso_oe;
  assign data_pending_o = s_r.irq;
  assign data_pending_oe = s_r.irq_oe;
  assign mode = s_r.mode;
  assign gate = s_r.gate;
  assign tx_power = s_r.pwr;
  assign host_wake_seen = s_r.wake_seen;
  assign fw_update_cmd = s_r.fw_cmd;

  // checks
  a_radio_excl: assert property (@(posedge mclk) disable iff (!rst_n)
    !(gate.rx_on && gate.tx_on)) else $error("rx and tx both on");
  a_reset_dark: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == lpms_pkg::LPMS_RESET |-> gate == '0)
    else $error("power on in reset");
  a_port_power: assert property (@(posedge mclk) disable iff (!rst_n)
    mode != lpms_pkg::LPMS_RESET |-> gate.host_port_on && gate.dig_reg_on)
    else $error("port off outside reset");
  a_standby_ls: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == lpms_pkg::LPMS_STANDBY |-> !gate.low_speed_osc_on &&
    !gate.core_on) else $error("standby gates wrong");
  a_sleep_hs: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == lpms_pkg::LPMS_SLEEP |-> !gate.high_speed_osc_on && !gate.synth_on)
    else $error("sleep gates wrong");
  a_active_core: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == lpms_pkg::LPMS_ACTIVE |-> gate.core_on && !gate.synth_on)
    else $error("active gates wrong");
  sequence s_timer_wake;
    mode == lpms_pkg::LPMS_SLEEP && timer_expired && s_r.sel_d == s_r.sel[1]
    && s_r.rst_pin[1];
  endsequence
  a_timer_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    s_timer_wake |=> mode == lpms_pkg::LPMS_WAKE && gate.high_speed_osc_on)
    else $error("timer wake missed");
  a_irq_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == lpms_pkg::LPMS_ACTIVE && data_ready && s_r.rst_pin[1]
    && !mode_req_valid && s_r.sleep_pend == 2'h0 |=> data_pending_o)
    else $error("pending flag missing");
  a_sleep_pins: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == lpms_pkg::LPMS_SLEEP |-> !port_miso_oe && !data_pending_oe)
    else $error("pins driven in sleep");
endmodule : lpms_sequencer

// ===== verification/lpms_host.sv
// host-side model: drives the serial port and resolves the pulled pins
`timescale 1ns/1ps
module lpms_host (
  // serial lines toward the device
  output logic port_clk,
  output logic port_select_n,
  output logic port_mosi,
  // device pins and their enables
  input wire logic port_miso_o,
  input wire logic port_miso_oe,
  input wire logic data_pending_o,
  input wire logic data_pending_oe,
  // levels as the host sees them
  output logic miso_pin,
  output logic irq_pin
);
  // released pins fall to their pull-downs, never to a stale level
  assign miso_pin = port_miso_oe ? port_miso_o : 1'b0;
  assign irq_pin = data_pending_oe ? data_pending_o : 1'b0;

  // idle: select high, clock parked low between frames
  initial begin
    port_clk = 1'b0;
    port_select_n = 1'b1;
    port_mosi = 1'b0;
  end

  // select low alone is the wake event for a sleeping device
  task automatic select(logic v);
    port_select_n = v;
  endtask : select

  // one byte msb first; 160 ns period keeps under the port ceiling
  task automatic send_byte(logic [7:0] b);
    port_select_n = 1'b0;
    #205;
    for (int i = 7; i >= 0; i--) begin
      port_mosi = b[i];
      #80 port_clk = 1'b1;
      #80 port_clk = 1'b0;
    end
    #200;
    port_select_n = 1'b1;
    port_mosi = ~b[0]; // released data line shows no stale bit
  endtask : send_byte
endmodule : lpms_host

// ===== verification/low_power_mode_sequencer_bench.sv
// self-checking bench for the low power mode sequencer
`timescale 1ns/1ps
module low_power_mode_sequencer_bench;
  localparam int WK = 30;
  // driven from the stimulus process from time zero, except mclk, which its always block toggles
  logic mclk, arst_n, ext_n, mrv, tmr, dr, b2, chg;
  logic [4:0] pwr_in;
  lpms_pkg::lpms_ls_e ls;
  lpms_pkg::lpms_req_e req;
  logic pclk, psel_n, mosi, miso_o, miso_oe, dp_o, dp_oe, miso_pin, irq_pin;
  logic wake_seen, fw_cmd;
  logic wake_hit = 1'b0;
  logic fw_hit = 1'b0;
  logic [4:0] pwr;
  lpms_pkg::lpms_mode_e mode;
  lpms_pkg::lpms_gate_s gate;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int lims[3] = '{44, 64, 84};
  int rq[10] = '{1, 2, 1, 0, 1, 0, 2, 0, 2, 0};
  int cc[10] = '{0, 0, 0, 0, 1, 0, 1, 0, 0, 0};
  int lm[10] = '{16, 34, 34, 8, 29, 8, 30, 8, 17, 8};
  int pv[3] = '{0, 26, 27};
  int pe[3] = '{0, 26, 26};

  always #4 mclk = ~mclk;

  // short counts keep the run brief; limits below add sync slack
  lpms_sequencer #(.RST_NONE(40), .RST_RO(60), .RST_XO(80), .WAKE(WK),
    .SBY_RO(50), .SBY_XO(70), .RX_CH(25), .RX_NC(12), .TX_CH(26),
    .TX_NC(13), .SW(30)) dut (
    .mclk(mclk), .arst_n(arst_n), .external_reset_n(ext_n),
    .port_clk(pclk), .port_select_n(psel_n), .port_mosi(mosi),
    .port_miso_o(miso_o), .port_miso_oe(miso_oe),
    .data_pending_o(dp_o), .data_pending_oe(dp_oe), .ls_src(ls),
    .bank2_off_cfg(b2), .channel_change(chg), .mode_req(req),
    .mode_req_valid(mrv), .timer_expired(tmr), .data_ready(dr),
    .tx_power_in(pwr_in), .mode(mode), .gate(gate), .tx_power(pwr),
    .host_wake_seen(wake_seen), .fw_update_cmd(fw_cmd));

  lpms_host host (
    .port_clk(pclk), .port_select_n(psel_n), .port_mosi(mosi),
    .port_miso_o(miso_o), .port_miso_oe(miso_oe),
    .data_pending_o(dp_o), .data_pending_oe(dp_oe),
    .miso_pin(miso_pin), .irq_pin(irq_pin));

  // one-cycle pulses are latched so a later compare cannot miss them
  always @(posedge mclk) begin
    cyc++;
    if (wake_seen === 1'b1) wake_hit = 1'b1;
    if (fw_cmd === 1'b1) fw_hit = 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("ERROR %0t run did not finish", $time);
      close_out();
    end
  end

  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic chk_val(logic [8:0] got, logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  // expected gates per mode; low-speed clock is free outside low power
  task automatic chk_gate;
    lpms_pkg::lpms_gate_s g;
    g = '0;
    if (mode !== lpms_pkg::LPMS_RESET) begin
      g.dig_reg_on = 1'b1;
      g.host_port_on = 1'b1;
      g.second_bank_on = 1'b1;
    end
    if (mode inside {lpms_pkg::LPMS_SLEEP, lpms_pkg::LPMS_STANDBY}) begin
      g.second_bank_on = !b2;
      g.low_speed_osc_on = (mode == lpms_pkg::LPMS_SLEEP);
    end else if (mode !== lpms_pkg::LPMS_RESET) begin
      g.low_speed_osc_on = (ls != lpms_pkg::LPMS_LS_NONE);
      g.high_speed_osc_on = 1'b1;
      g.core_on = 1'b1;
      g.rx_on = (mode == lpms_pkg::LPMS_RX);
      g.tx_on = (mode == lpms_pkg::LPMS_TX);
      g.synth_on = g.rx_on | g.tx_on;
    end
    chk_val(9'(gate), 9'(g));
  endtask : chk_gate

  // bounded wait: missing the limit is itself the mismatch
  task automatic wait_mode(lpms_pkg::lpms_mode_e t, int lim);
    int n;
    n = 0;
    while (mode !== t && n <= lim) begin
      step(1);
      n++;
    end
    chk_val(9'(mode), 9'(t));
  endtask : wait_mode

  task automatic ask(lpms_pkg::lpms_req_e r);
    req = r;
    mrv = 1'b1;
    step(1);
    mrv = 1'b0;
  endtask : ask

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    ext_n = 1'b0;
    mrv = 1'b0;
    tmr = 1'b0;
    dr = 1'b0;
    b2 = 1'b0;
    chg = 1'b0;
    pwr_in = 5'h00;
    ls = lpms_pkg::LPMS_LS_NONE;
    req = lpms_pkg::LPMS_REQ_ACTIVE;
    step(5);
    chk_val(9'(mode), 9'(lpms_pkg::LPMS_RESET));
    arst_n = 1'b1;
    // boot once per low-speed clock source
    for (int i = 0; i < 3; i++) begin
      ls = lpms_pkg::lpms_ls_e'(i);
      ext_n = 1'b0;
      step(5);
      chk_val(9'(mode), 9'(lpms_pkg::LPMS_RESET));
      chk_gate();
      ext_n = 1'b1;
      wait_mode(lpms_pkg::LPMS_ACTIVE, lims[i]);
      chk_gate();
    end
    dr = 1'b1;
    step(3);
    chk_val(9'(irq_pin), 9'h001);
    for (int i = 0; i < 3; i++) begin
      pwr_in = 5'(pv[i]);
      step(2);
      chk_val(9'(pwr), 9'(pe[i]));
    end
    // radio walk: rx, tx and active requests, both settle lengths, rx-tx switches
    for (int i = 0; i < 10; i++) begin
      chg = cc[i][0];
      ask(lpms_pkg::lpms_req_e'(rq[i]));
      wait_mode(rq[i] == 1 ? lpms_pkg::LPMS_RX : rq[i] == 2 ?
        lpms_pkg::LPMS_TX : lpms_pkg::LPMS_ACTIVE, lm[i]);
      chk_gate();
    end
    // sleep on ring clock, second bank dropped, timer wake
    ls = lpms_pkg::LPMS_LS_RING;
    b2 = 1'b1;
    ask(lpms_pkg::LPMS_REQ_SLEEP);
    wait_mode(lpms_pkg::LPMS_SLEEP, 8);
    chk_gate();
    chk_val(9'({miso_oe, dp_oe, irq_pin}), 9'h000);
    tmr = 1'b1;
    step(1);
    tmr = 1'b0;
    wait_mode(lpms_pkg::LPMS_ACTIVE, WK + 4);
    // sleep again, host wakes it by select
    ask(lpms_pkg::LPMS_REQ_SLEEP);
    wait_mode(lpms_pkg::LPMS_SLEEP, 8);
    wake_hit = 1'b0;
    host.select(1'b0);
    wait_mode(lpms_pkg::LPMS_ACTIVE, WK + 8);
    host.select(1'b1);
    chk_val(9'(wake_hit), 9'h001);
    // standby: timer is deaf, host select still wakes
    ls = lpms_pkg::LPMS_LS_NONE;
    b2 = 1'b0;
    ask(lpms_pkg::LPMS_REQ_SLEEP);
    wait_mode(lpms_pkg::LPMS_STANDBY, 8);
    chk_gate();
    tmr = 1'b1;
    step(1);
    tmr = 1'b0;
    step(20);
    chk_val(9'(mode), 9'(lpms_pkg::LPMS_STANDBY));
    host.select(1'b0);
    wait_mode(lpms_pkg::LPMS_ACTIVE, WK + 8);
    host.select(1'b1);
    // firmware command byte versus an ordinary byte
    step(4);
    fw_hit = 1'b0;
    host.send_byte(8'h7F);
    step(6);
    chk_val(9'(fw_hit), 9'h000);
    host.send_byte(8'h80);
    step(6);
    chk_val(9'(fw_hit), 9'h001);
    close_out();
  end
endmodule : low_power_mode_sequencer_bench
